// ---- rtl/sbc_regs.svh ----
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
`define SBC_CLK_PERIOD_NS 100
`define SBC_PRECHARGE_PERIOD_NS 15
`define SBC_ROW_TO_COLUMN_DELAY_NS 15
`define SBC_WRITE_RECOVERY_TIME_NS 15
`define SBC_ROW_CYCLE_TIME_NS 60
`define SBC_MODE_SET_DELAY_CK 2
`define SBC_CEIL_CK(ns) (((ns) + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_PRECHARGE_CK `SBC_CEIL_CK(`SBC_PRECHARGE_PERIOD_NS)
`define SBC_ROW_TO_COLUMN_CK `SBC_CEIL_CK(`SBC_ROW_TO_COLUMN_DELAY_NS)
`define SBC_WRITE_RECOVERY_CK `SBC_CEIL_CK(`SBC_WRITE_RECOVERY_TIME_NS)
`define SBC_ROW_CYCLE_CK `SBC_CEIL_CK(`SBC_ROW_CYCLE_TIME_NS)
`define SBC_BURST_CK 4
`define SBC_BEAT_BOUNDARY 2
`define SBC_BANKS 4
`endif

// ---- rtl/sbc_pkg.sv ----
package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_CMD_NOP, SBC_CMD_DESELECT, SBC_CMD_READ, SBC_CMD_WRITE,
    SBC_CMD_ROW_OPEN, SBC_CMD_CLOSE, SBC_CMD_REFRESH, SBC_CMD_MODE_SET
  } sbc_cmd_t;
  typedef enum logic [3:0] {
    SBC_IDLE, SBC_ACTIVE, SBC_READ, SBC_WRITE, SBC_READ_AC, SBC_WRITE_AC,
    SBC_PRECHARGE, SBC_ACTIVATING, SBC_WREC, SBC_WREC_AC, SBC_REFRESH, SBC_MODE
  } sbc_state_t;
endpackage : sbc_pkg

// ---- rtl/sbc_link_if.sv ----
interface sbc_link_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank;
  logic autoclose_flag_bit;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, bank, autoclose_flag_bit);
  modport mem (input cs_n, ras_n, cas_n, we_n, bank, autoclose_flag_bit);
endinterface : sbc_link_if

// ---- rtl/sbc_device.sv ----
`include "sbc_regs.svh"
module sbc_device #(
  parameter int BANKS = `SBC_BANKS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  sbc_link_if.mem link,
  input wire logic i_burst_len8,
  output logic o_illegal,
  output logic o_accepted,
  output logic [3:0] o_bank0_state,
  output logic [BANKS-1:0] o_bank_idle
);
  import sbc_pkg::*;
  sbc_cmd_t cmd;
  sbc_state_t st_r [BANKS];
  sbc_state_t st_nxt [BANKS];
  logic [3:0] cnt_r [BANKS];
  logic [3:0] cnt_nxt [BANKS];
  logic [3:0] bcnt_r [BANKS];
  logic [3:0] bcnt_nxt [BANKS];
  sbc_state_t st_tmr [BANKS];
  logic [3:0] cnt_tmr [BANKS];
  logic [3:0] bcnt_tmr [BANKS];
  logic illegal_nxt;
  logic acc_nxt;
  logic illegal_r;
  logic acc_r;
  logic all_idle;
  logic dev_busy;

  always_comb begin
    if (link.cs_n) begin
      cmd = SBC_CMD_DESELECT;
    end else begin
      case ({link.ras_n, link.cas_n, link.we_n})
        3'h7: cmd = SBC_CMD_NOP;
        3'h5: cmd = SBC_CMD_READ;
        3'h4: cmd = SBC_CMD_WRITE;
        3'h3: cmd = SBC_CMD_ROW_OPEN;
        3'h2: cmd = SBC_CMD_CLOSE;
        3'h1: cmd = SBC_CMD_REFRESH;
        default: cmd = SBC_CMD_MODE_SET;
      endcase
    end
  end

  always_comb begin
    all_idle = 1'b1;
    dev_busy = 1'b0;
    for (int b = 0; b < BANKS; b++) begin
      if (st_r[b] != SBC_IDLE) all_idle = 1'b0;
      if (st_r[b] == SBC_REFRESH || st_r[b] == SBC_MODE) dev_busy = 1'b1;
    end
  end

  always_comb begin
    logic bad;
    logic hit;
    logic quiet;
    logic [3:0] len;
    bad = 1'b0;
    hit = 1'b0;
    quiet = (cmd == SBC_CMD_NOP) || (cmd == SBC_CMD_DESELECT);
    len = i_burst_len8 ? 4'(`SBC_BURST_CK) : 4'(`SBC_BEAT_BOUNDARY);
    for (int b = 0; b < BANKS; b++) begin
      st_nxt[b] = st_r[b];
      cnt_nxt[b] = (cnt_r[b] != 4'h0) ? cnt_r[b] - 4'h1 : 4'h0;
      bcnt_nxt[b] = (bcnt_r[b] != 4'h0) ? bcnt_r[b] - 4'h1 : 4'h0;
      // timers alone, kept for a refused command
      st_tmr[b] = st_r[b];
      cnt_tmr[b] = cnt_nxt[b];
      bcnt_tmr[b] = bcnt_nxt[b];
      case (st_r[b])
        SBC_IDLE, SBC_ACTIVE: st_tmr[b] = st_r[b];
        SBC_READ: if (bcnt_r[b] <= 4'h1) st_tmr[b] = SBC_ACTIVE;
        SBC_WRITE, SBC_WRITE_AC: begin
          if (bcnt_r[b] <= 4'h1) begin
            st_tmr[b] = (st_r[b] == SBC_WRITE) ? SBC_WREC : SBC_WREC_AC;
            cnt_tmr[b] = 4'(`SBC_WRITE_RECOVERY_CK);
          end
        end
        SBC_READ_AC, SBC_WREC_AC: begin
          if (((st_r[b] == SBC_READ_AC) ? bcnt_r[b] : cnt_r[b]) <= 4'h1) begin
            st_tmr[b] = SBC_PRECHARGE;
            cnt_tmr[b] = 4'(`SBC_PRECHARGE_CK);
          end
        end
        SBC_ACTIVATING, SBC_WREC: if (cnt_r[b] <= 4'h1) st_tmr[b] = SBC_ACTIVE;
        SBC_PRECHARGE, SBC_REFRESH, SBC_MODE: if (cnt_r[b] <= 4'h1) st_tmr[b] = SBC_IDLE;
        default: st_tmr[b] = SBC_IDLE;
      endcase
      hit = (link.bank == 2'(b)) || (cmd == SBC_CMD_REFRESH) ||
        (cmd == SBC_CMD_MODE_SET) || (cmd == SBC_CMD_CLOSE && link.autoclose_flag_bit);
      case (st_r[b])
        SBC_IDLE: begin
          if (hit && !quiet && !dev_busy) begin
            case (cmd)
              SBC_CMD_ROW_OPEN: begin
                st_nxt[b] = SBC_ACTIVATING;
                cnt_nxt[b] = 4'(`SBC_ROW_TO_COLUMN_CK);
              end
              SBC_CMD_CLOSE: begin
                st_nxt[b] = SBC_PRECHARGE;
                cnt_nxt[b] = 4'(`SBC_PRECHARGE_CK);
              end
              SBC_CMD_REFRESH: begin
                if (!all_idle) bad = 1'b1;
                else begin
                  st_nxt[b] = SBC_REFRESH;
                  cnt_nxt[b] = 4'(`SBC_ROW_CYCLE_CK);
                end
              end
              SBC_CMD_MODE_SET: begin
                if (!all_idle) bad = 1'b1;
                else begin
                  st_nxt[b] = SBC_MODE;
                  cnt_nxt[b] = 4'(`SBC_MODE_SET_DELAY_CK);
                end
              end
              default: bad = 1'b1;
            endcase
          end
        end
        SBC_ACTIVE, SBC_READ, SBC_WRITE: begin
          if (st_r[b] != SBC_ACTIVE && bcnt_r[b] <= 4'h1 && (quiet || !hit))
            st_nxt[b] = (st_r[b] == SBC_WRITE) ? SBC_WREC : SBC_ACTIVE;
          if (st_r[b] == SBC_WRITE && bcnt_r[b] <= 4'h1 && (quiet || !hit))
            cnt_nxt[b] = 4'(`SBC_WRITE_RECOVERY_CK);
          if (hit && !quiet) begin
            if (cmd == SBC_CMD_READ || cmd == SBC_CMD_WRITE) begin
              if (st_r[b] != SBC_ACTIVE && (!i_burst_len8 ||
                  (cmd == SBC_CMD_READ) != (st_r[b] == SBC_READ) ||
                  bcnt_r[b] != 4'(`SBC_BEAT_BOUNDARY)) && bcnt_r[b] != 4'h0)
                bad = 1'b1;
              else begin
                bcnt_nxt[b] = len;
                if (cmd == SBC_CMD_READ)
                  st_nxt[b] = link.autoclose_flag_bit ? SBC_READ_AC : SBC_READ;
                else
                  st_nxt[b] = link.autoclose_flag_bit ? SBC_WRITE_AC : SBC_WRITE;
              end
            end else if (cmd == SBC_CMD_CLOSE && st_r[b] == SBC_ACTIVE) begin
              st_nxt[b] = SBC_PRECHARGE;
              cnt_nxt[b] = 4'(`SBC_PRECHARGE_CK);
            end else bad = 1'b1;
          end
        end
        SBC_READ_AC, SBC_WRITE_AC: begin
          if (hit && !quiet) bad = 1'b1;
          if (bcnt_r[b] <= 4'h1) begin
            st_nxt[b] = (st_r[b] == SBC_WRITE_AC) ? SBC_WREC_AC : SBC_PRECHARGE;
            cnt_nxt[b] = (st_r[b] == SBC_WRITE_AC) ?
              4'(`SBC_WRITE_RECOVERY_CK) : 4'(`SBC_PRECHARGE_CK);
          end
        end
        SBC_PRECHARGE: begin
          if (hit && !quiet && cmd != SBC_CMD_CLOSE) bad = 1'b1;
          if (cnt_r[b] <= 4'h1) st_nxt[b] = SBC_IDLE;
        end
        SBC_ACTIVATING: begin
          if (hit && !quiet) bad = 1'b1;
          if (cnt_r[b] <= 4'h1) st_nxt[b] = SBC_ACTIVE;
        end
        SBC_WREC: begin
          if (hit && cmd == SBC_CMD_WRITE) begin
            st_nxt[b] = link.autoclose_flag_bit ? SBC_WRITE_AC : SBC_WRITE;
            bcnt_nxt[b] = len;
          end else if (hit && !quiet) bad = 1'b1;
          else if (cnt_r[b] <= 4'h1) st_nxt[b] = SBC_ACTIVE;
        end
        SBC_WREC_AC: begin
          if (hit && !quiet) bad = 1'b1;
          if (cnt_r[b] <= 4'h1) begin
            st_nxt[b] = SBC_PRECHARGE;
            cnt_nxt[b] = 4'(`SBC_PRECHARGE_CK);
          end
        end
        SBC_REFRESH: begin
          if (!quiet) bad = 1'b1;
          if (cnt_r[b] <= 4'h1) st_nxt[b] = SBC_IDLE;
        end
        SBC_MODE: begin
          if (!quiet) bad = 1'b1;
          if (cnt_r[b] <= 4'h1) st_nxt[b] = SBC_IDLE;
        end
        default: st_nxt[b] = SBC_IDLE;
      endcase
    end
    // a refused command changes no bank; timers still run
    if (bad) begin
      for (int b = 0; b < BANKS; b++) begin
        st_nxt[b] = st_tmr[b];
        cnt_nxt[b] = cnt_tmr[b];
        bcnt_nxt[b] = bcnt_tmr[b];
      end
    end
    illegal_nxt = bad;
    acc_nxt = !bad && !quiet;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int b = 0; b < BANKS; b++) begin
        st_r[b] <= SBC_IDLE;
        cnt_r[b] <= 4'h0;
        bcnt_r[b] <= 4'h0;
      end
      illegal_r <= 1'b0;
      acc_r <= 1'b0;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        st_r[b] <= st_nxt[b];
        cnt_r[b] <= cnt_nxt[b];
        bcnt_r[b] <= bcnt_nxt[b];
      end
      illegal_r <= illegal_nxt;
      acc_r <= acc_nxt;
    end
  end

  assign o_illegal = illegal_r;
  assign o_accepted = acc_r;
  assign o_bank0_state = st_r[0];
  always_comb begin
    for (int b = 0; b < BANKS; b++) o_bank_idle[b] = (st_r[b] == SBC_IDLE);
  end
endmodule : sbc_device

// ---- rtl/sbc_ctrl.sv ----
// controller end: drives one requested command per cycle, else no-op
module sbc_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst,
  sbc_link_if.ctrl link,
  input wire logic i_req,
  input wire sbc_pkg::sbc_cmd_t i_cmd,
  input wire logic [1:0] i_bank,
  input wire logic i_autoclose,
  input wire logic i_all_idle,
  output logic o_ready
);
  import sbc_pkg::*;
  logic [3:0] pins_r;
  logic [3:0] pins_nxt;
  logic [2:0] addr_r;
  logic [2:0] addr_nxt;
  logic gate;

  // refresh and mode set held back until all banks idle
  assign gate = !((i_cmd == SBC_CMD_REFRESH || i_cmd == SBC_CMD_MODE_SET) &&
    !i_all_idle);
  assign o_ready = gate;

  always_comb begin
    pins_nxt = 4'h7;
    addr_nxt = addr_r;
    if (i_req && gate) begin
      addr_nxt = {i_bank, i_autoclose};
      case (i_cmd)
        SBC_CMD_DESELECT: pins_nxt = 4'hf;
        SBC_CMD_READ: pins_nxt = 4'h5;
        SBC_CMD_WRITE: pins_nxt = 4'h4;
        SBC_CMD_ROW_OPEN: pins_nxt = 4'h3;
        SBC_CMD_CLOSE: pins_nxt = 4'h2;
        SBC_CMD_REFRESH: pins_nxt = 4'h1;
        SBC_CMD_MODE_SET: pins_nxt = 4'h0;
        default: pins_nxt = 4'h7;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pins_r <= 4'hf;
      addr_r <= 3'h0;
    end else begin
      pins_r <= pins_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign link.cs_n = pins_r[3];
  assign link.ras_n = pins_r[2];
  assign link.cas_n = pins_r[1];
  assign link.we_n = pins_r[0];
  assign link.bank = addr_r[2:1];
  assign link.autoclose_flag_bit = addr_r[0];
endmodule : sbc_ctrl

// ---- testbench/sbc_asserts.sv ----
module sbc_asserts
  import sbc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank,
  input wire logic autoclose_flag_bit,
  input wire logic o_illegal,
  input wire logic o_accepted,
  input wire logic [3:0] o_bank0_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic quiet;
  logic rw;
  logic close_c;
  logic hit;
  sbc_state_t st;
  assign st = sbc_state_t'(o_bank0_state);
  assign quiet = cs_n | (ras_n & cas_n & we_n);
  assign rw = !cs_n & ras_n & !cas_n;
  assign close_c = !cs_n & !ras_n & cas_n & !we_n;
  // command reaches bank 0: own address, refresh, mode set or all-bank close
  assign hit = !quiet & ((bank == 2'h0) | (!ras_n & !cas_n) | (close_c & autoclose_flag_bit));
  chk_quiet_legal: assert property (quiet |=> !o_illegal)
    else $error("quiet command flagged illegal");
  chk_idle_rw: assert property (st == SBC_IDLE && rw && hit |=> o_illegal)
    else $error("access to idle bank not flagged");
  chk_idle_open: assert property (st == SBC_IDLE && hit && !ras_n && cas_n && we_n
    |=> o_accepted && st == SBC_ACTIVATING) else $error("row open on idle bank failed");
  chk_ac_burst: assert property ((st == SBC_READ_AC || st == SBC_WRITE_AC) && hit
    |=> o_illegal) else $error("command during autoclose burst accepted");
  chk_pre_idle: assert property (st == SBC_PRECHARGE |=> st == SBC_IDLE)
    else $error("precharge did not end in idle");
  chk_pre_bad: assert property (st == SBC_PRECHARGE && hit && !close_c |=> o_illegal)
    else $error("command during precharge accepted");
  chk_act_done: assert property (st == SBC_ACTIVATING |=> st == SBC_ACTIVE)
    else $error("activating did not end in active");
  chk_act_bad: assert property (st == SBC_ACTIVATING && hit |=> o_illegal)
    else $error("command during activating accepted");
  chk_wrec_write: assert property (st == SBC_WREC && rw && !we_n && hit |=> o_accepted)
    else $error("write during recovery refused");
  chk_wrecac_next: assert property (st == SBC_WREC_AC |=> st == SBC_PRECHARGE)
    else $error("autoclose recovery did not precharge");
  chk_busy_block: assert property ((st == SBC_REFRESH || st == SBC_MODE)
    && !quiet |=> o_illegal) else $error("command during refresh or mode set accepted");
  cov_accept: cover property (o_accepted);
  cov_wrec: cover property (st == SBC_WREC);
  cov_busy: cover property (st == SBC_MODE && !quiet);
endmodule : sbc_asserts

// ---- testbench/sdram_bank_state_command_check_tb_top.sv ----
`define SBC_CHK(n, e, g) begin checks++; if ((e) !== (g)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module sdram_bank_state_command_check_tb_top;
  import sbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // f: check state, check illegal, check accepted, accepted, illegal
  typedef struct packed {
    sbc_cmd_t c;
    logic [1:0] b;
    logic ac;
    logic [4:0] f;
    sbc_state_t st;
  } sbc_row_t;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_autoclose = 1'b0;
  logic i_burst_len8 = 1'b0;
  logic [1:0] i_bank = 2'h0;
  sbc_cmd_t i_cmd = SBC_CMD_NOP;
  logic o_illegal, o_accepted, o_ready;
  logic [3:0] o_bank0_state, o_bank_idle;
  int errors = 0;
  int checks = 0;
  sbc_row_t rows [28];
  sbc_row_t w;
  always #50 i_core_clk = ~i_core_clk;
  sbc_link_if sbc_link_if_i ();
  sbc_ctrl sbc_ctrl_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(sbc_link_if_i),
    .i_req(i_req), .i_cmd(i_cmd), .i_bank(i_bank), .i_autoclose(i_autoclose),
    .i_all_idle(&o_bank_idle), .o_ready(o_ready));
  sbc_device sbc_device_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(sbc_link_if_i),
    .i_burst_len8(i_burst_len8), .o_illegal(o_illegal), .o_accepted(o_accepted),
    .o_bank0_state(o_bank0_state), .o_bank_idle(o_bank_idle));
  sbc_asserts sbc_asserts_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .cs_n(sbc_link_if_i.cs_n), .ras_n(sbc_link_if_i.ras_n), .cas_n(sbc_link_if_i.cas_n),
    .we_n(sbc_link_if_i.we_n), .bank(sbc_link_if_i.bank),
    .autoclose_flag_bit(sbc_link_if_i.autoclose_flag_bit), .o_illegal(o_illegal),
    .o_accepted(o_accepted), .o_bank0_state(o_bank0_state));
  task send(input sbc_cmd_t c, input logic [1:0] b, input logic ac);
    @(posedge i_core_clk);
    #1;
    i_req = (c != SBC_CMD_NOP);
    i_cmd = c;
    i_bank = b;
    i_autoclose = ac;
  endtask : send
  task final_report;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    rows = '{default: '0};
    rows[0] = '{SBC_CMD_ROW_OPEN, 2'h0, 1'b0, 5'h1e, SBC_ACTIVATING};
    rows[1] = '{SBC_CMD_READ, 2'h0, 1'b0, 5'h1d, SBC_ACTIVE};
    rows[2] = '{SBC_CMD_ROW_OPEN, 2'h1, 1'b0, 5'h1e, SBC_ACTIVE};
    rows[3] = '{SBC_CMD_WRITE, 2'h0, 1'b0, 5'h1e, SBC_WRITE};
    rows[6] = '{SBC_CMD_WRITE, 2'h0, 1'b0, 5'h06, SBC_IDLE};
    rows[7] = '{SBC_CMD_WRITE, 2'h0, 1'b0, 5'h19, SBC_WRITE};
    rows[10] = '{SBC_CMD_CLOSE, 2'h0, 1'b0, 5'h1e, SBC_PRECHARGE};
    rows[11] = '{SBC_CMD_CLOSE, 2'h0, 1'b0, 5'h18, SBC_IDLE};
    rows[12] = '{SBC_CMD_CLOSE, 2'h0, 1'b1, 5'h08, SBC_IDLE};
    rows[13] = '{SBC_CMD_READ, 2'h0, 1'b0, 5'h1d, SBC_IDLE};
    rows[14] = '{SBC_CMD_READ, 2'h0, 1'b0, 5'h19, SBC_IDLE};
    rows[15] = '{SBC_CMD_REFRESH, 2'h0, 1'b0, 5'h0e, SBC_IDLE};
    rows[16] = '{SBC_CMD_WRITE, 2'h2, 1'b0, 5'h09, SBC_IDLE};
    rows[18] = '{SBC_CMD_MODE_SET, 2'h0, 1'b0, 5'h0e, SBC_IDLE};
    rows[19] = '{SBC_CMD_ROW_OPEN, 2'h3, 1'b0, 5'h09, SBC_IDLE};
    rows[22] = '{SBC_CMD_ROW_OPEN, 2'h0, 1'b0, 5'h0e, SBC_IDLE};
    rows[24] = '{SBC_CMD_WRITE, 2'h0, 1'b1, 5'h1e, SBC_WRITE_AC};
    rows[25] = '{SBC_CMD_READ, 2'h0, 1'b0, 5'h09, SBC_IDLE};
    repeat (5) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    for (int i = 0; i < 28; i++) begin
      send(rows[i].c, rows[i].b, rows[i].ac);
      if (i >= 2) begin
        w = rows[i-2];
        if (w.f[2]) `SBC_CHK("accepted", w.f[1], o_accepted)
        if (w.f[3]) `SBC_CHK("illegal", w.f[0], o_illegal)
        if (w.f[4]) `SBC_CHK("bank0 state", w.st, sbc_state_t'(o_bank0_state))
      end
    end
    send(SBC_CMD_ROW_OPEN, 2'h1, 1'b0);
    repeat (3) send(SBC_CMD_NOP, 2'h0, 1'b0);
    send(SBC_CMD_REFRESH, 2'h0, 1'b0);
    #1;
    `SBC_CHK("ready", 1'b0, o_ready)
    send(SBC_CMD_ROW_OPEN, 2'h0, 1'b0);
    i_burst_len8 = 1'b1;
    send(SBC_CMD_NOP, 2'h0, 1'b0);
    send(SBC_CMD_READ, 2'h0, 1'b0);
    send(SBC_CMD_WRITE, 2'h0, 1'b0);
    repeat (2) send(SBC_CMD_NOP, 2'h0, 1'b0);
    `SBC_CHK("read cut by write", 1'b1, o_illegal)
    i_rst = 1'b1;
    send(SBC_CMD_NOP, 2'h0, 1'b0);
    `SBC_CHK("reset state", SBC_IDLE, sbc_state_t'(o_bank0_state))
    `SBC_CHK("reset idle", 4'hf, o_bank_idle)
    i_rst = 1'b0;
    final_report();
  end
endmodule : sdram_bank_state_command_check_tb_top
